// ===== tsa_alert_logic.sv
// Status flags, alert masking, alert pin routing and thermal input.
// Assumes a byte register port from the serial engine, with one-cycle
// rd/wr strobes, and fault conditions from the measurement blocks.

// Function
// - Diode open/short sets status bits 7, 6
// - Bit 5: fourth fan slow or timer limit
// - Bits 4..2: third, second, first fan slow
// - Bit 1: overtemperature; bit 0 unused
// - Flags sticky until cause gone, then read
// - Alert held while fault, until status read
// - Mask gates alert only, flag still sets
// - First mask register bit map
// - Second mask register bit map
// - Mask bit 5 gates timer when thermal
// - Alert function disabled after reset
// - Fourth config bit 0 routes alert pin
// - Third config bit 0 routes other pin
// - Third config bit 1 enables thermal pin
// - Time external low on thermal pin
// - Boost runs fans full while pin low
// - Boost only affects already running fans
// - First status bit 7 summarises second
// - High limit strict, low limit inclusive
module tsa_alert_logic (
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  clk_en_in,
  input  wire tsa_pkg::tsa_reg_req_t reg_req_in,
  output logic                [7:0]  reg_rdata_out,
  input  wire tsa_pkg::tsa_chan_t    chan_in [tsa_pkg::NUM_CHAN],
  input  wire logic                  diode_two_fault_in,
  input  wire logic                  diode_one_fault_in,
  input  wire logic           [3:0]  fan_slow_in,
  input  wire logic                  timer_over_limit_in,
  input  wire logic                  overtemperature_in,
  input  wire logic           [3:0]  fan_running_in,
  input  wire logic                  thermal_event_pin_in,
  output logic                       thermal_event_pin_out,
  output logic                       thermal_event_pin_oe_out,
  output logic                       thermal_low_time_out,
  output logic                [3:0]  fan_boost_out,
  output logic                       alert_on_supply_pin_out,
  output logic                       alert_on_supply_pin_oe_out,
  output logic                       alert_other_pin_out,
  output logic                       alert_other_pin_oe_out
);

  // ***************************************************
  // Declarations
  // ***************************************************
  localparam int NUM_CHAN_W = tsa_pkg::NUM_CHAN;

  logic [7:0] alert_mask_first;
  logic [7:0] alert_mask_second;
  logic [7:0] config_third;
  logic [7:0] config_fourth;
  logic [7:0] next_alert_mask_first;
  logic [7:0] next_alert_mask_second;
  logic [7:0] next_config_third;
  logic [7:0] next_config_fourth;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic       alert;
  logic       next_alert;
  logic       thermal_low;
  logic       next_thermal_low;
  logic [3:0] boost;
  logic [3:0] next_boost;
  logic [7:0] cond_first;
  logic [7:0] cond_second;
  logic [7:0] flags_first;
  logic [7:0] flags_second;
  logic [7:0] status_first_view;
  logic       second_register_summary;
  logic       thermal_en;
  logic       fourth_fan_or_timer_flag;
  logic       alert_pin_enabled;
  logic [NUM_CHAN_W-1:0] chan_out_of_limit;

  function automatic logic hit(input tsa_pkg::tsa_reg_req_t req,
                               input logic [7:0] ofs);
    hit = (req.addr == ofs);
  endfunction : hit

  // ***************************************************
  // Limit comparison per analog channel
  // ***************************************************
  // Channel order: 0 two-five, 1 supply, 2 remote one, 3 local,
  // 4 remote two
  genvar c;
  generate
    for (c = 0; c < NUM_CHAN_W; c++) begin : g_chan
      assign chan_out_of_limit[c] =
        (chan_in[c].reading > chan_in[c].high) |
        (chan_in[c].reading <= chan_in[c].low);
    end
  endgenerate

  // ***************************************************
  // Status conditions
  // ***************************************************
  assign thermal_en = config_third[tsa_pkg::BIT_THERMAL_EN];
  // Fourth tach pin doubles as thermal input, so bit 5 follows the timer
  assign fourth_fan_or_timer_flag = thermal_en ? timer_over_limit_in
                                               : fan_slow_in[3];

  always_comb begin
    cond_second = 8'h00;
    cond_second[tsa_pkg::BIT_DIODE_TWO] = diode_two_fault_in;
    cond_second[tsa_pkg::BIT_DIODE_ONE] = diode_one_fault_in;
    cond_second[tsa_pkg::BIT_FOURTH_FAN] = fourth_fan_or_timer_flag;
    cond_second[tsa_pkg::BIT_FIRST_FAN +: 3] = fan_slow_in[2:0];
    cond_second[tsa_pkg::BIT_OVERTEMP] = overtemperature_in;
    cond_first = 8'h00;
    cond_first[tsa_pkg::BIT_TWO_FIVE]   = chan_out_of_limit[0];
    cond_first[tsa_pkg::BIT_SUPPLY]     = chan_out_of_limit[1];
    cond_first[tsa_pkg::BIT_REMOTE_ONE] = chan_out_of_limit[2];
    cond_first[tsa_pkg::BIT_LOCAL]      = chan_out_of_limit[3];
    cond_first[tsa_pkg::BIT_REMOTE_TWO] = chan_out_of_limit[4];
  end

  // Flags set regardless of mask state
  tsa_sticky_bank #(
    .USED (tsa_pkg::USED_FIRST)
  ) u_status_first (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .clk_en_in (clk_en_in),
    .cond_in   (cond_first),
    .rd_clr_in (reg_req_in.rd & hit(reg_req_in, tsa_pkg::OFS_STATUS_FIRST)),
    .flags_out (flags_first)
  );

  tsa_sticky_bank #(
    .USED (tsa_pkg::USED_SECOND)
  ) u_status_second (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .clk_en_in (clk_en_in),
    .cond_in   (cond_second),
    .rd_clr_in (reg_req_in.rd & hit(reg_req_in, tsa_pkg::OFS_STATUS_SECOND)),
    .flags_out (flags_second)
  );

  // Summary follows the second bank live, so it clears with it
  assign second_register_summary = |flags_second;
  always_comb begin
    status_first_view = flags_first;
    status_first_view[tsa_pkg::BIT_SUMMARY] = second_register_summary;
  end

  // ***************************************************
  // Register writes and reads
  // ***************************************************
  always_comb begin
    next_alert_mask_first  = alert_mask_first;
    next_alert_mask_second = alert_mask_second;
    next_config_third      = config_third;
    next_config_fourth     = config_fourth;
    next_rdata             = rdata;
    if (reg_req_in.wr) begin
      if (hit(reg_req_in, tsa_pkg::OFS_MASK_FIRST)) begin
        next_alert_mask_first = reg_req_in.wdata;
      end
      if (hit(reg_req_in, tsa_pkg::OFS_MASK_SECOND)) begin
        next_alert_mask_second = reg_req_in.wdata;
      end
      if (hit(reg_req_in, tsa_pkg::OFS_CONFIG_THIRD)) begin
        next_config_third = reg_req_in.wdata;
      end
      if (hit(reg_req_in, tsa_pkg::OFS_CONFIG_FOURTH)) begin
        next_config_fourth = reg_req_in.wdata;
      end
    end
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        tsa_pkg::OFS_STATUS_FIRST:  next_rdata = status_first_view;
        tsa_pkg::OFS_STATUS_SECOND: next_rdata = flags_second;
        tsa_pkg::OFS_MASK_FIRST:    next_rdata = alert_mask_first;
        tsa_pkg::OFS_MASK_SECOND:   next_rdata = alert_mask_second;
        tsa_pkg::OFS_CONFIG_THIRD:  next_rdata = config_third;
        tsa_pkg::OFS_CONFIG_FOURTH: next_rdata = config_fourth;
        default:                    next_rdata = tsa_pkg::RDATA_UNMAP;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      alert_mask_first  <= tsa_pkg::RST_MASK;
      alert_mask_second <= tsa_pkg::RST_MASK;
      config_third      <= tsa_pkg::RST_CONFIG;
      config_fourth     <= tsa_pkg::RST_CONFIG;
      rdata             <= tsa_pkg::RST_RDATA;
    end else if (clk_en_in) begin
      alert_mask_first  <= next_alert_mask_first;
      alert_mask_second <= next_alert_mask_second;
      config_third      <= next_config_third;
      config_fourth     <= next_config_fourth;
      rdata             <= next_rdata;
    end
  end

  // ***************************************************
  // Alert generation and pin routing
  // ***************************************************
  assign alert_pin_enabled =
    config_fourth[tsa_pkg::BIT_ALERT_SUPPLY] |
    config_third[tsa_pkg::BIT_ALERT_OTHER];

  // Mask bit 5 covers whichever source drives status bit 5
  always_comb begin
    next_alert =
      (|(flags_first & ~alert_mask_first & tsa_pkg::USED_FIRST)) |
      ((|(flags_second & ~alert_mask_second & tsa_pkg::USED_SECOND)) &
       ~alert_mask_first[tsa_pkg::BIT_SUMMARY]);
    next_alert = next_alert & alert_pin_enabled;
  end

  // ***************************************************
  // Thermal input and fan boost
  // ***************************************************
  always_comb begin
    next_thermal_low = thermal_en & ~thermal_event_pin_in;
    // Stopped fans stay stopped; boost only raises running ones
    next_boost = {4{next_thermal_low &
                    config_third[tsa_pkg::BIT_BOOST]}} &
                 fan_running_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      alert       <= 1'b0;
      thermal_low <= 1'b0;
      boost       <= 4'h0;
    end else if (clk_en_in) begin
      alert       <= next_alert;
      thermal_low <= next_thermal_low;
      boost       <= next_boost;
    end
  end

  // Open-drain: drive low only while asserting
  assign alert_on_supply_pin_out    = 1'b0;
  assign alert_on_supply_pin_oe_out =
    alert & config_fourth[tsa_pkg::BIT_ALERT_SUPPLY];
  assign alert_other_pin_out        = 1'b0;
  assign alert_other_pin_oe_out     =
    alert & config_third[tsa_pkg::BIT_ALERT_OTHER];
  // Output mode of the thermal pin lives elsewhere; input only here
  assign thermal_event_pin_out      = 1'b0;
  assign thermal_event_pin_oe_out   = 1'b0;
  assign thermal_low_time_out       = thermal_low;
  assign fan_boost_out              = boost;
  assign reg_rdata_out              = rdata;

  // ***************************************************
  // Assertions
  // ***************************************************
  logic rd_second;
  assign rd_second = reg_req_in.rd &
                     hit(reg_req_in, tsa_pkg::OFS_STATUS_SECOND);

  property p_diode_sets;
    @(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && diode_two_fault_in && diode_one_fault_in |=>
      flags_second[7] && flags_second[6];
  endproperty
  a_diode_sets: assert property (p_diode_sets)
    else $error("diode fault did not set flags");

  property p_timer_source;
    @(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && thermal_en && timer_over_limit_in |=> flags_second[5];
  endproperty
  a_timer_source: assert property (p_timer_source)
    else $error("timer limit did not set bit 5");

  property p_fans_set;
    @(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in |=> (flags_second[4:2] & $past(fan_slow_in[2:0]))
                  == $past(fan_slow_in[2:0]);
  endproperty
  a_fans_set: assert property (p_fans_set)
    else $error("fan slow flag missing");

  property p_sticky_hold;
    @(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && flags_second[1] && !rd_second |=> flags_second[1];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("status flag dropped without read");

  property p_read_clears;
    @(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && rd_second && !overtemperature_in |=> !flags_second[1];
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("read did not clear idle flag");

  sequence s_unmasked_fault;
    clk_en_in && alert_pin_enabled && overtemperature_in &&
    !alert_mask_second[1] && !alert_mask_first[7];
  endsequence
  property p_alert_follows;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_unmasked_fault ##1 clk_en_in && $stable(config_third) &&
      $stable(config_fourth) && $stable(alert_mask_first) &&
      $stable(alert_mask_second) |=> alert;
  endproperty
  a_alert_follows: assert property (p_alert_follows)
    else $error("alert not raised for unmasked fault");

  property p_masked_sets;
    @(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && alert_mask_second[4] && fan_slow_in[2] |=>
      flags_second[4];
  endproperty
  a_masked_sets: assert property (p_masked_sets)
    else $error("masked source did not set flag");

  property p_disabled_quiet;
    @(posedge clk_in) disable iff (!rst_b_in)
    !config_third[0] && !config_fourth[0] |->
      !alert_on_supply_pin_oe_out && !alert_other_pin_oe_out;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("alert pin driven while disabled");

  property p_boost;
    @(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && thermal_en && config_third[2] && !thermal_event_pin_in
    |=> fan_boost_out == $past(fan_running_in);
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost not applied to running fans");

  property p_summary;
    @(posedge clk_in) disable iff (!rst_b_in)
    clk_en_in && reg_req_in.rd &&
    hit(reg_req_in, tsa_pkg::OFS_STATUS_FIRST) |=>
      reg_rdata_out[7] == $past(|flags_second);
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary bit disagrees with second status");

endmodule : tsa_alert_logic

// ===== tsa_pkg.sv
// Constants and carriers for the thermal status and alert logic.
// Assumes a byte-wide register port from the serial interface engine.
package tsa_pkg;

  // ***************************************************
  // Register offsets
  // ***************************************************
  localparam logic [7:0] OFS_STATUS_FIRST  = 8'h41;
  localparam logic [7:0] OFS_STATUS_SECOND = 8'h42;
  localparam logic [7:0] OFS_MASK_FIRST    = 8'h74;
  localparam logic [7:0] OFS_MASK_SECOND   = 8'h75;
  localparam logic [7:0] OFS_CONFIG_THIRD  = 8'h78;
  localparam logic [7:0] OFS_CONFIG_FOURTH = 8'h7D;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int BIT_SUMMARY       = 7;
  localparam int BIT_REMOTE_TWO    = 6;
  localparam int BIT_LOCAL         = 5;
  localparam int BIT_REMOTE_ONE    = 4;
  localparam int BIT_SUPPLY        = 2;
  localparam int BIT_TWO_FIVE      = 0;
  localparam int BIT_DIODE_TWO     = 7;
  localparam int BIT_DIODE_ONE     = 6;
  localparam int BIT_FOURTH_FAN    = 5;
  localparam int BIT_FIRST_FAN     = 2;
  localparam int BIT_OVERTEMP      = 1;
  localparam int BIT_ALERT_OTHER   = 0;
  localparam int BIT_THERMAL_EN    = 1;
  localparam int BIT_BOOST         = 2;
  localparam int BIT_ALERT_SUPPLY  = 0;

  // Implemented bits; the rest read as zero, save first bit 7, which reads the summary
  localparam logic [7:0] USED_FIRST  = 8'h75;
  localparam logic [7:0] USED_SECOND = 8'hFE;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_CONFIG  = 8'h00;
  localparam logic [7:0] RST_RDATA   = 8'h00;
  localparam logic [7:0] RDATA_UNMAP = 8'h00;

  // Analog channels compared against high and low limits
  localparam int NUM_CHAN = 5;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsa_reg_req_t;

  typedef struct packed {
    logic [7:0] reading;
    logic [7:0] high;
    logic [7:0] low;
  } tsa_chan_t;

endpackage : tsa_pkg

// ===== tsa_sticky_bank.sv
// Bank of sticky flags cleared by a read once the cause has gone.
// Assumes conditions and read strobe are synchronous to clk_in.
module tsa_sticky_bank #(
  parameter logic [7:0] USED = 8'hFF
) (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       clk_en_in,
  input  wire logic [7:0] cond_in,
  input  wire logic       rd_clr_in,
  output logic      [7:0] flags_out
);

  logic [7:0] flags;
  logic [7:0] next_flags;

  // ***************************************************
  // Per-bit sticky logic
  // ***************************************************
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      if (USED[g]) begin : g_used
        // A live condition wins over the read clear
        always_comb begin
          next_flags[g] = cond_in[g] | (flags[g] & ~rd_clr_in);
        end
      end else begin : g_unused
        always_comb begin
          next_flags[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flags <= 8'h00;
    end else if (clk_en_in) begin
      flags <= next_flags;
    end
  end

  assign flags_out = flags;

endmodule : tsa_sticky_bank

// ===== tsa_host_model.sv
// Host processor model: byte register port and the shared alert wire.
// Assumes open-drain alert pins with a pull-up and a clock from the bench.
module tsa_host_model (
  input  wire logic                  clk_in,
  input  wire logic            [7:0] reg_rdata_in,
  input  wire logic                  sup_out_in,
  input  wire logic                  sup_oe_in,
  input  wire logic                  oth_out_in,
  input  wire logic                  oth_oe_in,
  output tsa_pkg::tsa_reg_req_t      reg_req_out,
  output logic                       alert_b_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial reg_req_out = '0;

  // Pull-up line, low while either enabled pin sinks it
  assign alert_b_out = ~((sup_oe_in & ~sup_out_in) |
                         (oth_oe_in & ~oth_out_in));

  // ***************************************************
  // Register cycles
  // ***************************************************
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    reg_req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk_in);
    reg_req_out <= '0;
  endtask : write_reg

  // Data is registered at the taking edge and held until the next read
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_in);
    reg_req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk_in);
    reg_req_out <= '0;
    #1;
    data = reg_rdata_in;
  endtask : read_reg

  // ***************************************************
  // Alert service
  // ***************************************************
  // Mask what is flagged so a lasting fault cannot tie up the host
  task automatic service(output logic [7:0] seen);
    read_reg(tsa_pkg::OFS_STATUS_SECOND, seen);
    write_reg(tsa_pkg::OFS_MASK_SECOND, seen);
  endtask : service

  // Poll a bounded number of times, unmask once the flag has gone
  task automatic poll_unmask(input logic [7:0] bits, output logic ok);
    logic [7:0] st;
    ok = 1'b0;
    for (int n = 0; n < 8 && !ok; n++) begin
      read_reg(tsa_pkg::OFS_STATUS_SECOND, st);
      if ((st & bits) == 8'h00) begin
        write_reg(tsa_pkg::OFS_MASK_SECOND, 8'h00);
        ok = 1'b1;
      end
    end
  endtask : poll_unmask
endmodule : tsa_host_model

// ===== tsa_alert_logic_tb.sv
// Self-checking bench for the thermal status and alert logic.
// Assumes the host model owns the register port and the alert wire.
module tsa_alert_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  clk_in = 1'b0;
  logic                  rst_b_in = 1'b0;
  logic            [6:0] src = 7'h00;
  logic                  timer_over = 1'b0;
  logic            [3:0] fan_run = 4'h0;
  logic                  ext_low = 1'b0;
  logic            [7:0] rv;
  logic            [7:0] rdata;
  tsa_pkg::tsa_reg_req_t req;
  tsa_pkg::tsa_chan_t    chan [tsa_pkg::NUM_CHAN];
  logic                  th_out, th_oe, th_pin, low_time;
  logic            [3:0] boost;
  logic                  sup_out, sup_oe, oth_out, oth_oe, alert_b;
  int                    errors = 0;
  int                    samples_checked = 0;
  // First status register bit of each analog channel
  int                    chan_bit [5] = '{0, 2, 4, 5, 6};

  initial begin
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    for (int k = 0; k < tsa_pkg::NUM_CHAN; k++) begin
      chan[k] = '{reading: 8'h80, high: 8'hC0, low: 8'h40};
    end
  end
  // Pulled-up thermal line, sunk by the device or by external logic
  assign th_pin = ~(ext_low | (th_oe & ~th_out));

  tsa_alert_logic i_tsa_alert_logic (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1),
    .reg_req_in(req), .reg_rdata_out(rdata), .chan_in(chan),
    .diode_two_fault_in(src[6]), .diode_one_fault_in(src[5]),
    .fan_slow_in(src[4:1]), .timer_over_limit_in(timer_over),
    .overtemperature_in(src[0]), .fan_running_in(fan_run),
    .thermal_event_pin_in(th_pin), .thermal_event_pin_out(th_out),
    .thermal_event_pin_oe_out(th_oe), .thermal_low_time_out(low_time),
    .fan_boost_out(boost), .alert_on_supply_pin_out(sup_out),
    .alert_on_supply_pin_oe_out(sup_oe), .alert_other_pin_out(oth_out),
    .alert_other_pin_oe_out(oth_oe));

  tsa_host_model i_tsa_host_model (
    .clk_in(clk_in), .reg_rdata_in(rdata), .sup_out_in(sup_out),
    .sup_oe_in(sup_oe), .oth_out_in(oth_out), .oth_oe_in(oth_oe),
    .reg_req_out(req), .alert_b_out(alert_b));

  // ***************************************************
  // Helpers
  // ***************************************************
  task automatic end_of_test;
    $display("Comparisons %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [7:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic check_pin(input logic got, exp, input string what);
    check({7'h00, got}, {7'h00, exp}, what);
  endtask : check_pin

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cycles

  task automatic rd(input logic [7:0] a);
    i_tsa_host_model.read_reg(a, rv);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_tsa_host_model.write_reg(a, d);
  endtask : wr

  // A hung alert counts against the run and ends it
  task automatic wait_alert(input logic lvl);
    int n = 0;
    while (alert_b !== lvl && n < 12) begin
      cycles(1);
      n++;
    end
    check_pin(alert_b, lvl, "alert level");
    if (alert_b !== lvl) end_of_test();
  endtask : wait_alert

  // ***************************************************
  // Scenarios
  // ***************************************************
  task automatic t_reset;
    logic [7:0] ofs [4] = '{
      tsa_pkg::OFS_STATUS_SECOND, tsa_pkg::OFS_MASK_FIRST,
      tsa_pkg::OFS_MASK_SECOND, tsa_pkg::OFS_CONFIG_THIRD};
    foreach (ofs[k]) begin
      rd(ofs[k]);
      check(rv, 8'h00, "reset value");
    end
    rd(tsa_pkg::OFS_CONFIG_FOURTH);
    check(rv, 8'h00, "reset config");
    check({6'h00, sup_oe, oth_oe}, 8'h00, "alert idle");
    wr(8'h13, 8'hA5);
    rd(8'h13);
    check(rv, 8'h00, "unmapped");
    wr(tsa_pkg::OFS_STATUS_SECOND, 8'hFF);
    rd(tsa_pkg::OFS_STATUS_SECOND);
    check(rv, 8'h00, "status write");
    wr(tsa_pkg::OFS_MASK_FIRST, 8'hA5);
    rd(tsa_pkg::OFS_MASK_FIRST);
    check(rv, 8'hA5, "mask one");
    wr(tsa_pkg::OFS_MASK_SECOND, 8'h5A);
    rd(tsa_pkg::OFS_MASK_SECOND);
    check(rv, 8'h5A, "mask two");
    wr(tsa_pkg::OFS_MASK_FIRST, 8'h00);
    wr(tsa_pkg::OFS_MASK_SECOND, 8'h00);
  endtask : t_reset

  task automatic t_status_map;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_in) src <= 7'h01 << i;
      cycles(2);
      rd(tsa_pkg::OFS_STATUS_SECOND);
      check(rv, 8'h01 << (i + 1), "flag");
      rd(tsa_pkg::OFS_STATUS_FIRST);
      check(rv, 8'h80, "summary");
      rd(tsa_pkg::OFS_STATUS_SECOND);
      check(rv, 8'h01 << (i + 1), "held while active");
      @(posedge clk_in) src <= 7'h00;
      cycles(2);
      rd(tsa_pkg::OFS_STATUS_SECOND);
      check(rv, 8'h01 << (i + 1), "sticky");
      rd(tsa_pkg::OFS_STATUS_SECOND);
      check(rv, 8'h00, "cleared");
      rd(tsa_pkg::OFS_STATUS_FIRST);
      check(rv, 8'h00, "summary off");
    end
  endtask : t_status_map

  task automatic t_alert;
    wr(tsa_pkg::OFS_CONFIG_THIRD, 8'h01);
    wr(tsa_pkg::OFS_CONFIG_FOURTH, 8'h01);
    @(posedge clk_in) src <= 7'h01;
    wait_alert(1'b0);
    check({6'h00, sup_oe, oth_oe}, 8'h03, "both pins");
    @(posedge clk_in) src <= 7'h00;
    cycles(4);
    check_pin(alert_b, 1'b0, "held until read");
    rd(tsa_pkg::OFS_STATUS_SECOND);
    wait_alert(1'b1);
    for (int i = 0; i < 7; i++) begin
      wr(tsa_pkg::OFS_MASK_SECOND, 8'h01 << (i + 1));
      @(posedge clk_in) src <= 7'h01 << i;
      cycles(4);
      check_pin(alert_b, 1'b1, "masked source");
      rd(tsa_pkg::OFS_STATUS_SECOND);
      check(rv, 8'h01 << (i + 1), "masked flag");
      @(posedge clk_in) src <= 7'h00;
      cycles(2);
      rd(tsa_pkg::OFS_STATUS_SECOND);
    end
    wr(tsa_pkg::OFS_MASK_SECOND, 8'h00);
    wr(tsa_pkg::OFS_MASK_FIRST, 8'h80);
    @(posedge clk_in) src <= 7'h10;
    cycles(4);
    check_pin(alert_b, 1'b1, "summary mask");
    @(posedge clk_in) src <= 7'h00;
    cycles(2);
    rd(tsa_pkg::OFS_STATUS_SECOND);
    wr(tsa_pkg::OFS_MASK_FIRST, 8'h00);
    wr(tsa_pkg::OFS_CONFIG_FOURTH, 8'h00);
    @(posedge clk_in) src <= 7'h01;
    wait_alert(1'b0);
    check({6'h00, sup_oe, oth_oe}, 8'h01, "other pin only");
    wr(tsa_pkg::OFS_CONFIG_THIRD, 8'h00);
    cycles(2);
    check({6'h00, sup_oe, oth_oe}, 8'h00, "no pin enabled");
    @(posedge clk_in) src <= 7'h00;
    cycles(2);
    rd(tsa_pkg::OFS_STATUS_SECOND);
  endtask : t_alert

  task automatic t_chan;
    wr(tsa_pkg::OFS_CONFIG_THIRD, 8'h01);
    for (int k = 0; k < tsa_pkg::NUM_CHAN; k++) begin
      @(posedge clk_in) chan[k].reading <= 8'hC0;
      cycles(3);
      rd(tsa_pkg::OFS_STATUS_FIRST);
      check(rv, 8'h00, "equal to high");
      wr(tsa_pkg::OFS_MASK_FIRST, 8'h01 << chan_bit[k]);
      @(posedge clk_in) chan[k].reading <= 8'hC1;
      cycles(4);
      check_pin(alert_b, 1'b1, "channel mask");
      rd(tsa_pkg::OFS_STATUS_FIRST);
      check(rv, 8'h01 << chan_bit[k], "above high");
      wr(tsa_pkg::OFS_MASK_FIRST, 8'h00);
      wait_alert(1'b0);
      @(posedge clk_in) chan[k].reading <= 8'h40;
      cycles(3);
      rd(tsa_pkg::OFS_STATUS_FIRST);
      check(rv, 8'h01 << chan_bit[k], "equal to low");
      @(posedge clk_in) chan[k].reading <= 8'h80;
      cycles(3);
      rd(tsa_pkg::OFS_STATUS_FIRST);
      wait_alert(1'b1);
    end
  endtask : t_chan

  task automatic t_thermal;
    @(posedge clk_in) fan_run <= 4'h5;
    wr(tsa_pkg::OFS_CONFIG_THIRD, 8'h07);
    @(posedge clk_in) ext_low <= 1'b1;
    cycles(3);
    check_pin(low_time, 1'b1, "low timed");
    check({4'h0, boost}, 8'h05, "boost running");
    @(posedge clk_in) ext_low <= 1'b0;
    cycles(3);
    check({3'h0, low_time, boost}, 8'h00, "boost off");
    wr(tsa_pkg::OFS_CONFIG_THIRD, 8'h05);
    @(posedge clk_in) ext_low <= 1'b1;
    cycles(3);
    check({3'h0, low_time, boost}, 8'h00, "thermal off");
    wr(tsa_pkg::OFS_CONFIG_THIRD, 8'h03);
    cycles(3);
    check({4'h0, boost}, 8'h00, "no boost bit");
    @(posedge clk_in) ext_low <= 1'b0;
    @(posedge clk_in) src <= 7'h10;
    cycles(3);
    rd(tsa_pkg::OFS_STATUS_SECOND);
    check(rv, 8'h00, "fan four ignored");
    @(posedge clk_in) src <= 7'h00;
    @(posedge clk_in) timer_over <= 1'b1;
    wait_alert(1'b0);
    rd(tsa_pkg::OFS_STATUS_SECOND);
    check(rv, 8'h20, "timer flag");
    wr(tsa_pkg::OFS_MASK_SECOND, 8'h20);
    wait_alert(1'b1);
    @(posedge clk_in) timer_over <= 1'b0;
    cycles(2);
    rd(tsa_pkg::OFS_STATUS_SECOND);
    wr(tsa_pkg::OFS_MASK_SECOND, 8'h00);
    wr(tsa_pkg::OFS_CONFIG_THIRD, 8'h01);
  endtask : t_thermal

  task automatic t_service;
    logic [7:0] seen;
    logic       ok;
    @(posedge clk_in) src <= 7'h04;
    wait_alert(1'b0);
    i_tsa_host_model.service(seen);
    check(seen, 8'h08, "serviced source");
    wait_alert(1'b1);
    @(posedge clk_in) src <= 7'h00;
    cycles(2);
    i_tsa_host_model.poll_unmask(8'h08, ok);
    check_pin(ok, 1'b1, "unmasked");
    rd(tsa_pkg::OFS_MASK_SECOND);
    check(rv, 8'h00, "mask restored");
    check_pin(alert_b, 1'b1, "quiet after service");
  endtask : t_service

  initial begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_status_map();
    t_alert();
    t_chan();
    t_thermal();
    t_service();
    end_of_test();
  end
endmodule : tsa_alert_logic_tb
